// ### src/sceme_pkg.sv
// Constants shared by the socket change event and mask logic
package sceme_pkg;

  // Register port widths
  localparam int unsigned SCEME_ADDR_W = 8;
  localparam int unsigned SCEME_DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [SCEME_ADDR_W-1:0] SCEME_FLAGS_OFS = 8'h00;
  localparam logic [SCEME_ADDR_W-1:0] SCEME_MASK_OFS  = 8'h04;

  // Number of implemented event positions in both registers
  localparam int unsigned SCEME_NUM_EVT = 4;

  // Field positions, shared by the flag and the enable register
  localparam int unsigned SCEME_BIT_CSTS = 0;
  localparam int unsigned SCEME_BIT_DET1 = 1;
  localparam int unsigned SCEME_BIT_DET2 = 2;
  localparam int unsigned SCEME_BIT_PWR  = 3;

  // Reset values
  localparam logic [SCEME_NUM_EVT-1:0] SCEME_FLAGS_RST = 4'h0;
  localparam logic [SCEME_NUM_EVT-1:0] SCEME_MASK_RST  = 4'h0;
  localparam logic [SCEME_DATA_W-1:0]  SCEME_RDATA_RST = 32'h0000_0000;

  // Two-bit detect enable code that lets insertion and removal through
  localparam logic [1:0] SCEME_DET_ON = 2'h3;

  // Filler for the reserved upper positions on read
  localparam logic [SCEME_DATA_W-SCEME_NUM_EVT-1:0] SCEME_RESERVED_RD = 28'h0;

endpackage : sceme_pkg

// ### src/sceme_chg_det.sv
// Per-bit rising and falling edge detector for synchronous levels
`timescale 1ns/1ps
`default_nettype none

module sceme_chg_det #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic             primed;
  } sceme_det_state_t;

  sceme_det_state_t st_ff;
  sceme_det_state_t nxt_st;

  // First cycle after reset only learns the level, so no false edge
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.prev   = level_in;
    nxt_st.primed = 1'b1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edge outputs per bit
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign rise_out[i] = st_ff.primed & level_in[i] & ~st_ff.prev[i];
      assign fall_out[i] = st_ff.primed & ~level_in[i] & st_ff.prev[i];
    end
  endgenerate

endmodule : sceme_chg_det

`default_nettype wire

// ### src/sceme_top.sv
// Socket status change flags, interrupt enables and status change request
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: Flags only record that a condition changed, never its direction.
// R02: Software reads present socket state elsewhere, not from the flags.
// R03: Writing 1 to a flag position clears it; 0 leaves it alone.
// R04: A 1 in the force-event input sets that flag like a change.
// R05: Reset clears every event flag.
// R06: Leaving card reset re-sets flags if status or detect still asserted.
// R07: Software clears all flags before enabling the interrupt.
// R08: A flag left set when enabled raises the interrupt at once.
// R09: Bits 31 to 4 of both registers read as zero.
// R10: Flag bit 3 sets on any power-cycle state change.
// R11: Flag bit 2 sets on any second card-detect state change.
// R12: Flag bit 1 sets on any first card-detect state change.
// R13: CardBus card: flag bit 0 sets only on card status rising edge.
// R14: 16-bit card: flag bit 0 sets on both card status edges.
// R15: Enables gate only the interrupt; flags set regardless.
// R16: Enable bit 3 high lets power-cycle flag raise the interrupt.
// R17: Detect enable bits 2:1 at 11 pass detect flags; 00 blocks.
// R18: Enable bit 0 high lets card status flag raise the interrupt.
// R19: Interrupt stands while any enabled flag is set, drops when none.
module sceme_top (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [sceme_pkg::SCEME_ADDR_W-1:0] reg_addr,
  input  wire logic [sceme_pkg::SCEME_DATA_W-1:0] reg_wdata,
  output logic      [sceme_pkg::SCEME_DATA_W-1:0] reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic                          power_cycle_state,
  input  wire logic                          detect2_state,
  input  wire logic                          detect1_state,
  input  wire logic                          card_status_state,
  input  wire logic                          card_is_cardbus,
  input  wire logic                          card_reset_release,
  input  wire logic [sceme_pkg::SCEME_NUM_EVT-1:0] force_event,
  output logic                               status_change_interrupt
);

  import sceme_pkg::*;

  typedef struct packed {
    logic [SCEME_NUM_EVT-1:0] flags;
    logic [SCEME_NUM_EVT-1:0] mask;
    logic [SCEME_DATA_W-1:0]  rdata;
    logic                     rvalid;
    logic                     irq;
  } sceme_state_t;

  sceme_state_t st_ff;
  sceme_state_t nxt_st;

  logic [SCEME_NUM_EVT-1:0] levels;
  logic [SCEME_NUM_EVT-1:0] rise;
  logic [SCEME_NUM_EVT-1:0] fall;
  logic [SCEME_NUM_EVT-1:0] chg;
  logic [SCEME_NUM_EVT-1:0] edge_set;
  logic [SCEME_NUM_EVT-1:0] release_set;
  logic [SCEME_NUM_EVT-1:0] evt_set;
  logic [SCEME_NUM_EVT-1:0] clr;
  logic                     wr_flags;
  logic                     wr_mask;
  logic                     rd_flags;
  logic                     rd_mask;

  // Monitored levels laid out at their flag positions
  always_comb begin
    levels                 = '0;
    levels[SCEME_BIT_PWR]  = power_cycle_state;
    levels[SCEME_BIT_DET2] = detect2_state;
    levels[SCEME_BIT_DET1] = detect1_state;
    levels[SCEME_BIT_CSTS] = card_status_state;
  end

  // Edge detection on all four monitored levels
  sceme_chg_det #(
    .WIDTH    (SCEME_NUM_EVT)
  ) u_chg_det (
    .mclk     (mclk),
    .reset    (reset),
    .level_in (levels),
    .rise_out (rise),
    .fall_out (fall)
  );

  // Expand the two-bit detect code into per-flag interrupt enables
  function automatic logic [SCEME_NUM_EVT-1:0] eff_mask(
    input logic [SCEME_NUM_EVT-1:0] m
  );
    logic det_on;
    det_on = (m[SCEME_BIT_DET2:SCEME_BIT_DET1] == SCEME_DET_ON); // R17
    eff_mask                 = '0;
    eff_mask[SCEME_BIT_PWR]  = m[SCEME_BIT_PWR];                 // R16
    eff_mask[SCEME_BIT_DET2] = det_on;
    eff_mask[SCEME_BIT_DET1] = det_on;
    eff_mask[SCEME_BIT_CSTS] = m[SCEME_BIT_CSTS];                // R18
  endfunction : eff_mask

  // Register decode
  assign wr_flags = reg_wr && (reg_addr == SCEME_FLAGS_OFS);
  assign wr_mask  = reg_wr && (reg_addr == SCEME_MASK_OFS);
  assign rd_flags = reg_rd && (reg_addr == SCEME_FLAGS_OFS);
  assign rd_mask  = reg_rd && (reg_addr == SCEME_MASK_OFS);

  // Write-one-to-clear pattern for the flag register
  assign clr = wr_flags ? reg_wdata[SCEME_NUM_EVT-1:0] : '0; // R03

  // Change events, direction discarded
  always_comb begin
    chg      = rise | fall;                                 // R01
    edge_set = '0;
    edge_set[SCEME_BIT_PWR]  = chg[SCEME_BIT_PWR];          // R10
    edge_set[SCEME_BIT_DET2] = chg[SCEME_BIT_DET2];         // R11
    edge_set[SCEME_BIT_DET1] = chg[SCEME_BIT_DET1];         // R12
    if (card_is_cardbus) begin
      edge_set[SCEME_BIT_CSTS] = rise[SCEME_BIT_CSTS];      // R13
    end else begin
      edge_set[SCEME_BIT_CSTS] = chg[SCEME_BIT_CSTS];       // R14
    end
  end

  // Status or detect still present when the card comes out of reset
  always_comb begin
    release_set = '0;
    if (card_reset_release) begin
      release_set[SCEME_BIT_CSTS] = card_status_state;      // R06
      release_set[SCEME_BIT_DET1] = detect1_state;          // R06
      release_set[SCEME_BIT_DET2] = detect2_state;          // R06
    end
  end

  // All set sources; force acts exactly like a real change
  assign evt_set = edge_set | release_set | force_event; // R04

  // Next state: flags, enables, read data and interrupt
  always_comb begin
    nxt_st        = st_ff;
    // Set wins over a clear in the same cycle, enables play no part
    nxt_st.flags  = (st_ff.flags & ~clr) | evt_set;         // R15
    if (wr_mask) begin
      nxt_st.mask = reg_wdata[SCEME_NUM_EVT-1:0];
    end
    nxt_st.rvalid = reg_rd;
    if (rd_flags) begin
      nxt_st.rdata = {SCEME_RESERVED_RD, st_ff.flags};      // R09
    end else if (rd_mask) begin
      nxt_st.rdata = {SCEME_RESERVED_RD, st_ff.mask};       // R09
    end else if (reg_rd) begin
      nxt_st.rdata = SCEME_RDATA_RST;
    end
    // Level request from the next-state flags and enables, registered with them
    nxt_st.irq = |(nxt_st.flags & eff_mask(nxt_st.mask));   // R08 R19
  end

  // State register; reset clears every flag
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff.flags  <= SCEME_FLAGS_RST;                      // R05
      st_ff.mask   <= SCEME_MASK_RST;
      st_ff.rdata  <= SCEME_RDATA_RST;
      st_ff.rvalid <= 1'b0;
      st_ff.irq    <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata               = st_ff.rdata;
  assign reg_rvalid              = st_ff.rvalid;
  assign status_change_interrupt = st_ff.irq;

  // Checks on the flag, enable and request behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Software write of ones to the flag register
  sequence s_clear_write;
    wr_flags && (reg_wdata[SCEME_NUM_EVT-1:0] != '0);
  endsequence

  // No set source active alongside that write
  sequence s_no_set;
    (evt_set == '0);
  endsequence

  // Enable write, then a set flag at an enabled position
  sequence s_enable_write;
    wr_mask ##1 ((st_ff.flags & eff_mask(st_ff.mask)) != '0);
  endsequence

  flag_clear_a : assert property ( // R03
    (s_clear_write and s_no_set) |=>
      ((st_ff.flags & $past(reg_wdata[SCEME_NUM_EVT-1:0])) == '0)
      && ((st_ff.flags | $past(reg_wdata[SCEME_NUM_EVT-1:0]))
          == ($past(st_ff.flags) | $past(reg_wdata[SCEME_NUM_EVT-1:0]))))
    else $error("flag clear pattern not honoured");

  force_set_a : assert property ( // R04
    (force_event != '0) |=>
      ((st_ff.flags & $past(force_event)) == $past(force_event)))
    else $error("forced event did not set its flag");

  pwr_change_a : assert property ( // R10
    (!$past(reset) && $changed(power_cycle_state)) |=>
      st_ff.flags[SCEME_BIT_PWR])
    else $error("power cycle change missed");

  det_change_a : assert property ( // R11
    (!$past(reset) && $changed(detect2_state)) |=>
      st_ff.flags[SCEME_BIT_DET2])
    else $error("second detect change missed");

  det1_change_a : assert property ( // R12
    (!$past(reset) && $changed(detect1_state)) |=>
      st_ff.flags[SCEME_BIT_DET1])
    else $error("first detect change missed");

  cb_fall_a : assert property ( // R13
    (card_is_cardbus && !$past(reset) && $fell(card_status_state)
     && !st_ff.flags[SCEME_BIT_CSTS] && !force_event[SCEME_BIT_CSTS]
     && !card_reset_release) |=> !st_ff.flags[SCEME_BIT_CSTS])
    else $error("cardbus falling status edge set the flag");

  both_edges_a : assert property ( // R14
    (!card_is_cardbus && !$past(reset)
     && $changed(card_status_state)) |=> st_ff.flags[SCEME_BIT_CSTS])
    else $error("16-bit card status edge missed");

  release_set_a : assert property ( // R06
    (card_reset_release && card_status_state) |=>
      st_ff.flags[SCEME_BIT_CSTS])
    else $error("status not re-flagged after card reset");

  reserved_field_zero_a : assert property ( // R09
    reg_rvalid |-> (reg_rdata[SCEME_DATA_W-1:SCEME_NUM_EVT] == '0))
    else $error("reserved bits read nonzero");

  irq_level_a : assert property ( // R19
    status_change_interrupt ==
      (|(st_ff.flags & eff_mask(st_ff.mask))))
    else $error("request does not follow enabled flags");

  irq_enable_a : assert property ( // R08
    s_enable_write |-> status_change_interrupt)
    else $error("pending flag gave no request after enable");

  det_gate_a : assert property ( // R17
    (st_ff.mask[SCEME_BIT_DET2:SCEME_BIT_DET1] != SCEME_DET_ON
     && !st_ff.mask[SCEME_BIT_PWR] && !st_ff.mask[SCEME_BIT_CSTS])
      |-> !status_change_interrupt)
    else $error("detect code other than on raised the request");

  // Flags and request come out of reset cleared
  flag_reset_a : assert property ( // R05
    $fell(reset) |-> ((st_ff.flags == '0) && !status_change_interrupt))
    else $error("flags or request not cleared by reset");

  // Detect levels still high at card reset release flag again
  rel_det1_a : assert property ( // R06
    (card_reset_release && detect1_state) |=> st_ff.flags[SCEME_BIT_DET1])
    else $error("first detect not re-flagged after card reset");

  rel_det2_a : assert property ( // R06
    (card_reset_release && detect2_state) |=> st_ff.flags[SCEME_BIT_DET2])
    else $error("second detect not re-flagged after card reset");

  // Rising status edge still flagged for a CardBus card
  cb_rise_a : assert property ( // R13
    (card_is_cardbus && !$past(reset) && $rose(card_status_state))
      |=> st_ff.flags[SCEME_BIT_CSTS])
    else $error("cardbus rising status edge missed");

  // Real changes set their flags whatever the enables hold
  mask_free_a : assert property ( // R15
    (edge_set != '0) |=>
      ((st_ff.flags & $past(edge_set)) == $past(edge_set)))
    else $error("change did not set its flag");

  // Each enabled single-bit flag raises the request on its own
  pwr_gate_a : assert property ( // R16
    (st_ff.flags[SCEME_BIT_PWR] && st_ff.mask[SCEME_BIT_PWR])
      |-> status_change_interrupt)
    else $error("enabled power cycle flag gave no request");

  csts_gate_a : assert property ( // R18
    (st_ff.flags[SCEME_BIT_CSTS] && st_ff.mask[SCEME_BIT_CSTS])
      |-> status_change_interrupt)
    else $error("enabled card status flag gave no request");

  // Read answer one cycle after the strobe, data held until the next read
  rd_answer_a : assert property (
    reg_rd |=> reg_rvalid)
    else $error("read strobe gave no answer");

  rdata_hold_a : assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule : sceme_top

`default_nettype wire

// ### tb/sceme_card_model.sv
// Card side model: socket levels answered with a selectable lag
`timescale 1ns/1ps
`default_nettype none

module sceme_card_model (
  input  wire logic       mclk,
  input  wire logic [3:0] lv_req,
  input  wire logic [1:0] lag,
  output logic      [3:0] lv_out
);
  logic [3:0] p0;
  logic [3:0] p1;
  logic [3:0] p2;

  // Delay line, one stage per cycle of lag
  always @(posedge mclk) begin
    p0 <= lv_req;
    p1 <= p0;
    p2 <= p1;
  end

  // Prompt or slow answer; lag only changes while the line is settled
  assign lv_out = (lag == 2'h0) ? p0 : (lag == 2'h1) ? p1 : p2;
endmodule : sceme_card_model

`default_nettype wire

// ### tb/socket_change_event_mask_tb.sv
// Self-checking bench for the socket change flags and enables
`timescale 1ns/1ps
`default_nettype none

module socket_change_event_mask_tb;
  import sceme_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        reg_rvalid, irq, cardbus = 1'b0, rel = 1'b0;
  logic [3:0]  lv = 4'h0, lv_card, frc = 4'h0, exp_f = 4'h0, msk = 4'h0;
  logic [1:0]  lag = 2'h0;
  logic [31:0] expq [$];
  int          mismatches = 0, check_count = 0, cyc = 0, seed = 11526;
  // Detect codes kept to 00 and 11 only
  logic [3:0]  on_t [4] = '{4'h1, 4'h6, 4'h6, 4'h8};
  logic [3:0]  off_t [4] = '{4'he, 4'h9, 4'h9, 4'h7};

  // Clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      results;
    end
  end

  sceme_top dut (
    .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_cycle_state(lv_card[3]),
    .detect2_state(lv_card[2]), .detect1_state(lv_card[1]),
    .card_status_state(lv_card[0]), .card_is_cardbus(cardbus),
    .card_reset_release(rel), .force_event(frc),
    .status_change_interrupt(irq)
  );
  sceme_card_model card (
    .mclk(mclk), .lv_req(lv), .lag(lag), .lv_out(lv_card)
  );

  // Read answers taken off the queue, oldest first
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      if (expq.size() == 0) chk("reg_rvalid", 32'h0, 32'h1);
      else chk("reg_rdata", expq.pop_front(), reg_rdata);
    end
  end

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Write with random filler in the reserved positions
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    reg_addr = a;
    reg_wdata = {28'($random(seed)), d};
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    tick;
  endtask : rd

  task automatic rdf;
    rd(SCEME_FLAGS_OFS, {28'h0, exp_f});
  endtask : rdf

  task automatic clr;
    wr(SCEME_FLAGS_OFS, 4'hf);
    exp_f = 4'h0;
  endtask : clr

  task automatic frc_pulse(input logic [3:0] p);
    frc = p;
    tick;
    frc = 4'h0;
    tick;
  endtask : frc_pulse

  // Card moves one level; expected flag noted from the edge kind
  task automatic lvl(input int i, input logic v);
    lag = 2'($random(seed));
    if (lv[i] !== v && (i != 0 || v || !cardbus)) exp_f[i] = 1'b1;
    lv[i] = v;
    repeat (6) tick;
  endtask : lvl

  task automatic cirq;
    logic e;
    e = |(exp_f & {msk[3], msk[2] & msk[1], msk[2] & msk[1], msk[0]});
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : cirq

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    tick;
    rdf;
    rd(SCEME_MASK_OFS, 32'h0);
    rd(8'h08, 32'h0);
    for (int i = 1; i < 4; i++) begin
      lvl(i, 1'b1);
      lvl(i, 1'b0);
      rdf;
      cirq;
    end
    wr(SCEME_FLAGS_OFS, 4'h5);
    exp_f = exp_f & 4'ha;
    rdf;
    wr(8'h0c, 4'hf);
    rdf;
    for (int k = 0; k < 2; k++) begin
      cardbus = k[0];
      clr;
      lvl(0, 1'b1);
      rdf;
      clr;
      lvl(0, 1'b0);
      rdf;
      cirq;
    end
    clr;
    exp_f = 4'($random(seed));
    frc_pulse(exp_f);
    rdf;
    frc = 4'h2;
    wr(SCEME_FLAGS_OFS, 4'hf);
    frc = 4'h0;
    exp_f = 4'h2;
    rdf;
    for (int k = 0; k < 4; k++) begin
      clr;
      msk = on_t[k];
      wr(SCEME_MASK_OFS, msk);
      rd(SCEME_MASK_OFS, {28'h0, msk});
      exp_f[k] = 1'b1;
      frc_pulse(exp_f);
      cirq;
      msk = off_t[k];
      wr(SCEME_MASK_OFS, msk);
      cirq;
    end
    msk = 4'h0;
    wr(SCEME_MASK_OFS, msk);
    clr;
    exp_f = 4'h8;
    frc_pulse(exp_f);
    msk = 4'hf;
    wr(SCEME_MASK_OFS, msk);
    cirq;
    clr;
    cirq;
    lvl(1, 1'b1);
    lvl(0, 1'b1);
    lvl(2, 1'b1);
    clr;
    rel = 1'b1;
    tick;
    rel = 1'b0;
    tick;
    exp_f = {1'b0, lv[2:0]};
    rdf;
    cirq;
    reset = 1'b1;
    repeat (2) tick;
    reset = 1'b0;
    tick;
    exp_f = 4'h0;
    msk = 4'h0;
    rdf;
    rd(SCEME_MASK_OFS, 32'h0);
    cirq;
    chk("pending", 32'h0, 32'(expq.size()));
    results;
  end
endmodule : socket_change_event_mask_tb

`default_nettype wire
